// >>> aspc_far_model.sv
// far-side audio controller: master clock pulses and slave port clocks
`timescale 1ns/100ps
module aspc_far_model
  import aspc_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic [1:0] i_sel, // master clock per port, 1 = clock two
  input wire logic [1:0][CNT_W-1:0] i_ratio, // master ticks per frame per port
  output logic o_mclk_one,
  output logic o_mclk_two,
  output logic [1:0] o_frame,
  output logic [1:0] o_bit
);
  int tick = 0; // shared divider, master clocks run free
  int phase [2] = '{0, 0}; // ticks into the current frame
  logic [1:0] step; // selected master pulse per port

  // clock one every 2 cycles, clock two every 3: unrelated rates
  always @(posedge i_core_clk)
  begin
    tick <= (tick + 1) % 6;
    o_mclk_one <= (tick % 2 == 0);
    o_mclk_two <= (tick % 3 == 0);
  end

  assign step = {i_sel[1] ? o_mclk_two : o_mclk_one, i_sel[0] ? o_mclk_two : o_mclk_one};

  always @(posedge i_core_clk)
  begin
    for (int p = 0; p < 2; p++)
      if (step[p])
        phase[p] <= (phase[p] + 1 >= int'(i_ratio[p])) ? 0 : phase[p] + 1;
  end

  always_comb
  begin
    for (int p = 0; p < 2; p++)
    begin
      o_frame[p] = phase[p] >= int'(i_ratio[p]) / 2;
      o_bit[p] = ((phase[p] * 128) / int'(i_ratio[p])) % 2 == 1;
    end
  end
endmodule : aspc_far_model

// >>> aspc_pkg.sv
// shared constants, types and ratio lookup for serial port clocking
package aspc_pkg;
  // register word addresses
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_RATIO = 4'h1;
  localparam logic [3:0] REG_STATUS = 4'h2;
  // control word: speed, role, source, auto, line routing
  localparam int CTRL_W = 10;
  localparam int CTRL_SPEED = 0;
  localparam int CTRL_MASTER = 2;
  localparam int CTRL_SRC = 4;
  localparam int CTRL_AUTO = 6;
  localparam int CTRL_LINE = 7;
  localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;
  // ratio word: one two-bit field per master clock
  localparam int RATIO_W = 4;
  localparam int FIELD_W = 2;
  localparam logic [RATIO_W-1:0] RATIO_RST = 4'h0;
  // status word positions
  localparam int STAT_ASYNC = 0;
  localparam int STAT_SPEED = 1;
  localparam int STAT_LOCK = 3;
  localparam int STAT_HW = 5;
  localparam int STAT_CNT = 6;
  // tick counters and the bit clock step (128 edges per frame)
  localparam int CNT_W = 10;
  localparam logic [CNT_W-1:0] CNT_MAX = 10'h3FF;
  localparam logic [CNT_W-1:0] BIT_STEP = 10'h080;
  localparam logic PINS_OE_N_RST = 1'b1;
  // speed encodings
  localparam logic SPEED_SINGLE = 1'b0;
  localparam logic SPEED_DOUBLE = 1'b1;
  // strap codes as {low pin, high pin}
  localparam logic [1:0] STRAP_MST_SS = 2'h0;
  localparam logic [1:0] STRAP_MST_DS = 2'h1;
  localparam logic [1:0] STRAP_RSVD = 2'h2;
  localparam logic [1:0] STRAP_SLV_AUTO = 2'h3;
  // ratio fields implied by the halve pin
  localparam logic [1:0] HW_FIELD_LO = 2'h0;
  localparam logic [1:0] HW_FIELD_HI = 2'h2;
  // master clock ticks per frame
  localparam logic [CNT_W-1:0] R128 = 10'h080;
  localparam logic [CNT_W-1:0] R192 = 10'h0C0;
  localparam logic [CNT_W-1:0] R256 = 10'h100;
  localparam logic [CNT_W-1:0] R384 = 10'h180;
  localparam logic [CNT_W-1:0] R512 = 10'h200;
  localparam logic [CNT_W-1:0] R768 = 10'h300;
  // port role, one-hot
  typedef enum logic [1:0] {ROLE_SLAVE = 2'b01, ROLE_MASTER = 2'b10} aspc_role_e;

  // ticks per frame for a speed and a ratio field
  function automatic logic [CNT_W-1:0] aspc_ratio(input logic speed,
                                                 input logic [1:0] field);
    logic [CNT_W-1:0] r;
    r = R256;
    case ({speed, field})
      3'h0: r = R256;
      3'h1: r = R384;
      3'h2: r = R512;
      3'h3: r = R768;
      3'h4: r = R128;
      3'h5: r = R192;
      3'h6: r = R256;
      3'h7: r = R384;
      default: r = R256;
    endcase
    return r;
  endfunction : aspc_ratio
endpackage : aspc_pkg

// >>> aspc_port_clkgen.sv
// one serial port: clock generation as master, measurement as slave
`timescale 1ns/100ps
module aspc_port_clkgen
  import aspc_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_bit_pin,
  input wire logic i_frame_pin,
  aspc_port_if.port p
);
  typedef struct packed {
    aspc_role_e role; // current role
    logic [CNT_W-1:0] phase; // tick within frame
    logic [CNT_W-1:0] acc; // bit clock accumulator
    logic [CNT_W-1:0] meas; // ticks since frame rise
    logic [CNT_W-1:0] count; // last measured frame
    logic bit_lvl;
    logic frame_lvl;
    logic oe_n;
    logic frame_prev; // edge detect on frame pin
    logic eff_speed;
    logic locked;
  } aspc_port_s;

  aspc_port_s s;
  aspc_port_s next_s;
  logic [CNT_W-1:0] ratio_n; // expected ticks per frame
  logic [CNT_W-1:0] acc_sum;
  logic [CNT_W-1:0] meas_sum; // saturating so a stopped frame cannot wrap
  logic frame_rise;

  assign ratio_n = aspc_ratio(p.speed, p.field);
  assign acc_sum = s.acc + BIT_STEP;
  assign meas_sum = (s.meas == CNT_MAX) ? CNT_MAX : s.meas + {9'h000, p.mclk_tick};
  assign frame_rise = i_frame_pin & ~s.frame_prev;

  // next state of the port
  always_comb
  begin
    next_s = s;
    next_s.frame_prev = i_frame_pin;
    case (s.role)
      // [R14] master drives derived clocks
      ROLE_MASTER:
      begin
        next_s.oe_n = 1'b0;
        next_s.eff_speed = p.speed;
        next_s.locked = 1'b1;
        if (p.mclk_tick)
        begin
          // [R8] [R9] 64 bit clocks per frame
          if (acc_sum >= ratio_n)
          begin
            next_s.acc = acc_sum - ratio_n;
            next_s.bit_lvl = ~s.bit_lvl;
          end
          else
          begin
            next_s.acc = acc_sum;
          end
          // [R6] [R5] frame wraps every ratio ticks
          if (s.phase >= ratio_n - 10'h001)
          begin
            next_s.phase = '0;
            next_s.frame_lvl = 1'b0;
            next_s.acc = '0;
            next_s.bit_lvl = 1'b0;
          end
          else
          begin
            next_s.phase = s.phase + 10'h001;
            next_s.frame_lvl = (s.phase + 10'h001) >= (ratio_n >> 1);
          end
        end
      end
      // [R14] slave follows pins, generator idle
      ROLE_SLAVE:
      begin
        next_s.oe_n = 1'b1;
        next_s.bit_lvl = i_bit_pin;
        next_s.frame_lvl = i_frame_pin;
        next_s.meas = meas_sum;
        if (!p.auto_en)
        begin
          next_s.eff_speed = p.speed;
        end
        if (frame_rise)
        begin
          next_s.meas = '0;
          next_s.count = meas_sum;
          // [R18] speed from measured ratio
          if (p.auto_en)
          begin
            if (meas_sum == aspc_ratio(SPEED_SINGLE, p.field))
            begin
              next_s.eff_speed = SPEED_SINGLE;
              next_s.locked = 1'b1;
            end
            else if (meas_sum == aspc_ratio(SPEED_DOUBLE, p.field))
            begin
              next_s.eff_speed = SPEED_DOUBLE;
              next_s.locked = 1'b1;
            end
            else
            begin
              next_s.locked = 1'b0;
            end
          end
          else
          begin
            // [R7] fixed speed expects fixed ratio
            next_s.locked = (meas_sum == ratio_n);
          end
        end
      end
      default: next_s.role = ROLE_SLAVE;
    endcase
    // role change: release pins first, restart counts
    if (p.master != (s.role == ROLE_MASTER))
    begin
      next_s.role = p.master ? ROLE_MASTER : ROLE_SLAVE;
      next_s.oe_n = 1'b1;
      next_s.phase = '0;
      next_s.acc = '0;
      next_s.meas = '0;
      next_s.locked = 1'b0;
    end
  end

  // state register
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      s <= '0;
      s.role <= ROLE_SLAVE;
      s.oe_n <= PINS_OE_N_RST;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign p.bit_level = s.bit_lvl;
  assign p.frame_level = s.frame_lvl;
  assign p.pins_oe_n = s.oe_n;
  assign p.eff_speed = s.eff_speed;
  assign p.locked = s.locked;
  assign p.count = s.count;

  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  frame_wrap_a: assert property ( // [R8]
    (s.role == ROLE_MASTER && p.master && p.mclk_tick && s.phase == ratio_n - 10'h001)
    |=> (s.phase == 10'h000 && !s.frame_lvl))
    else $error("frame did not wrap at ratio");
  frame_half_a: assert property ( // [R6]
    (s.role == ROLE_MASTER && p.master && p.mclk_tick
     && s.phase == (ratio_n >> 1) - 10'h001) |=> s.frame_lvl)
    else $error("frame clock not high at half frame");
  slave_release_a: assert property ( // [R14]
    !p.master |=> p.pins_oe_n)
    else $error("slave port still drives pins");
  master_drive_a: assert property ( // [R14]
    p.master [*2] |=> !p.pins_oe_n)
    else $error("master port not driving pins");
  auto_double_a: assert property ( // [R18]
    (s.role == ROLE_SLAVE && !p.master && p.auto_en && frame_rise
     && meas_sum == aspc_ratio(SPEED_DOUBLE, p.field)) |=> (p.eff_speed && p.locked))
    else $error("double speed ratio not detected");
endmodule : aspc_port_clkgen

// >>> aspc_port_if.sv
// configuration and status bundle between top and one port generator
`timescale 1ns/100ps
interface aspc_port_if;
  logic mclk_tick; // selected master clock enable
  logic master; // port drives its clocks
  logic speed; // configured speed
  logic auto_en; // speed taken from measurement
  logic [1:0] field; // ratio field of selected clock
  logic bit_level; // bit clock as seen or driven
  logic frame_level; // frame clock as seen or driven
  logic pins_oe_n; // low while driving pins
  logic eff_speed; // speed in force
  logic locked; // frame matches expected ratio
  logic [9:0] count; // ticks in last slave frame
  modport ctl(output mclk_tick, master, speed, auto_en, field,
              input bit_level, frame_level, pins_oe_n, eff_speed, locked, count);
  modport port(input mclk_tick, master, speed, auto_en, field,
               output bit_level, frame_level, pins_oe_n, eff_speed, locked, count);
endinterface : aspc_port_if

// >>> aspc_top.sv
// serial audio port clocking: registers, pin decode, two port generators
//
// Contract
// [R1] two speed ranges, single and double
// [R2] two ports, each own frame/bit pair
// [R3] each data line picks its port
// [R4] per port speed and role independent
// [R5] master and frame clocks integer ratio
// [R6] frame clock runs at sample rate
// [R7] speed bits and fields set clocks
// [R8] single speed ratios 256/384/512/768
// [R9] double speed ratios 128/192/256/384
// [R10] reset: synchronous, both on clock one
// [R11] synchronous ports may differ in speed
// [R12] differing sources give asynchronous mode
// [R13] hardware mode uses clock one only
// [R14] slave pins input, master pins driven
// [R15] far side derives slave frame clock
// [R16] straps set role and speed
// [R17] far side keeps bit clock ratio
// [R18] auto detection derives speed from ratio
//
// The address map and strobed register access were decided locally.
`timescale 1ns/100ps
module aspc_top
  import aspc_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // register port
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wr_data,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  output logic [31:0] o_rd_data,
  // hardware configuration pins
  input wire logic i_hw_mode,
  input wire logic i_strap_pin_low,
  input wire logic i_strap_pin_high,
  input wire logic i_master_clock_halve_pin,
  // master clock enables, one pulse per period
  input wire logic i_master_clock_one,
  input wire logic i_master_clock_two,
  // port pins, index 0 is port one
  input wire logic [1:0] i_bit_clock,
  input wire logic [1:0] i_frame_clock,
  output logic [1:0] o_bit_clock,
  output logic [1:0] o_bit_clock_oe_n,
  output logic [1:0] o_frame_clock,
  output logic [1:0] o_frame_clock_oe_n,
  // clocks for output line, input one, input two
  output logic [2:0] o_line_bit_clock,
  output logic [2:0] o_line_frame_clock,
  output logic o_async_mode
);
  typedef struct packed {
    logic [CTRL_W-1:0] ctrl; // speed, role, source, auto, lines
    logic [RATIO_W-1:0] ratio; // master_clock_ratio_field per clock
    logic [31:0] rdata; // read data, one cycle only
    logic [2:0] line_bit; // routed bit clocks
    logic [2:0] line_frame; // routed frame clocks
    logic async; // ports on different sources
  } aspc_top_s;

  aspc_top_s s;
  aspc_top_s next_s;

  aspc_port_if pif[2] ();

  logic [1:0] strap; // {low, high}
  logic [1:0] src_sel; // port_clock_source_select in force
  logic [1:0] port_bit; // levels of each port
  logic [1:0] port_frame;
  logic [1:0] port_speed; // speed in force per port
  logic [1:0] port_lock;
  logic [2:0] line_src; // port used by each data line
  logic [CNT_W-1:0] port_count [2];
  logic [31:0] status; // assembled status word
  logic async_now;

  assign strap = {i_strap_pin_low, i_strap_pin_high};

  // per port decode and generator
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_port
      // [R13] hardware mode forces clock one
      assign src_sel[g] = i_hw_mode ? 1'b0 : s.ctrl[CTRL_SRC+g];
      // [R12] each port runs on its own source
      assign pif[g].mclk_tick = src_sel[g] ? i_master_clock_two : i_master_clock_one;
      // [R7] field follows the selected clock
      assign pif[g].field = i_hw_mode ?
        (i_master_clock_halve_pin ? HW_FIELD_HI : HW_FIELD_LO) :
        s.ratio[src_sel[g]*FIELD_W +: FIELD_W];
      // [R16] straps decide role in hardware mode
      assign pif[g].master = i_hw_mode ?
        (strap == STRAP_MST_SS || strap == STRAP_MST_DS) : s.ctrl[CTRL_MASTER+g];
      // [R1] [R4] [R11] per port speed
      assign pif[g].speed = i_hw_mode ? (strap == STRAP_MST_DS) : s.ctrl[CTRL_SPEED+g];
      // reserved strap code: slave, fixed single speed, pins released
      assign pif[g].auto_en = i_hw_mode ? (strap == STRAP_SLV_AUTO) : s.ctrl[CTRL_AUTO];

      // [R2] own pin pair per port
      aspc_port_clkgen u_port (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_bit_pin(i_bit_clock[g]),
        .i_frame_pin(i_frame_clock[g]),
        .p(pif[g])
      );

      assign port_bit[g] = pif[g].bit_level;
      assign port_frame[g] = pif[g].frame_level;
      assign port_speed[g] = pif[g].eff_speed;
      assign port_lock[g] = pif[g].locked;
      assign port_count[g] = pif[g].count;
      // pin drivers are flops inside the generator
      assign o_bit_clock[g] = pif[g].bit_level;
      assign o_frame_clock[g] = pif[g].frame_level;
      assign o_bit_clock_oe_n[g] = pif[g].pins_oe_n;
      assign o_frame_clock_oe_n[g] = pif[g].pins_oe_n;
    end
    for (g = 0; g < 3; g++)
    begin : g_line
      // [R3] line routing, port one in hardware mode
      assign line_src[g] = i_hw_mode ? 1'b0 : s.ctrl[CTRL_LINE+g];
    end
  endgenerate

  // [R12] [R10] asynchronous only when sources differ
  assign async_now = !i_hw_mode && (s.ctrl[CTRL_SRC] != s.ctrl[CTRL_SRC+1]);

  // status word seen by software
  always_comb
  begin
    status = 32'h0000_0000;
    status[STAT_ASYNC] = s.async;
    status[STAT_SPEED +: 2] = port_speed;
    status[STAT_LOCK +: 2] = port_lock;
    status[STAT_HW] = i_hw_mode;
    status[STAT_CNT +: CNT_W] = port_count[0];
    status[STAT_CNT+CNT_W +: CNT_W] = port_count[1];
  end

  // next state: register writes, reads, routing
  always_comb
  begin
    next_s = s;
    // read data stand for one cycle only
    next_s.rdata = 32'h0000_0000;
    if (i_wr_en)
    begin
      case (i_addr)
        REG_CTRL: next_s.ctrl = i_wr_data[CTRL_W-1:0];
        REG_RATIO: next_s.ratio = i_wr_data[RATIO_W-1:0];
        // status and unmapped writes are dropped
        default: next_s.ctrl = s.ctrl;
      endcase
    end
    if (i_rd_en)
    begin
      case (i_addr)
        REG_CTRL: next_s.rdata = {22'h000000, s.ctrl};
        REG_RATIO: next_s.rdata = {28'h0000000, s.ratio};
        REG_STATUS: next_s.rdata = status;
        // unmapped reads return zero
        default: next_s.rdata = 32'h0000_0000;
      endcase
    end
    next_s.async = async_now;
    // registered so data paths see glitch-free levels, one cycle late
    for (int k = 0; k < 3; k++)
    begin
      next_s.line_bit[k] = port_bit[line_src[k]];
      next_s.line_frame[k] = port_frame[line_src[k]];
    end
  end

  // state register
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      // [R10] sources cleared, synchronous mode
      s <= '0;
      s.ctrl <= CTRL_RST;
      s.ratio <= RATIO_RST;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign o_rd_data = s.rdata;
  assign o_line_bit_clock = s.line_bit;
  assign o_line_frame_clock = s.line_frame;
  assign o_async_mode = s.async;

  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  // checks on decode and routing
  sync_reset_a: assert property ( // [R10]
    !$past(i_rst_n) |-> (s.ctrl[CTRL_SRC +: 2] == 2'b00 && !o_async_mode))
    else $error("not synchronous after reset");
  async_entry_a: assert property ( // [R12]
    (!i_hw_mode && s.ctrl[CTRL_SRC] != s.ctrl[CTRL_SRC+1]) |=> o_async_mode)
    else $error("asynchronous mode not entered");
  sync_stay_a: assert property ( // [R11]
    (s.ctrl[CTRL_SRC] == s.ctrl[CTRL_SRC+1]) |=> !o_async_mode)
    else $error("asynchronous mode with equal sources");
  hw_source_a: assert property ( // [R13]
    i_hw_mode |=> (!o_async_mode && $past(src_sel) == 2'b00))
    else $error("hardware mode left clock one");
  strap_slave_a: assert property ( // [R16]
    (i_hw_mode && strap == STRAP_SLV_AUTO) [*3] |-> (&o_bit_clock_oe_n && &o_frame_clock_oe_n))
    else $error("slave strap still drives clocks");
  strap_master_a: assert property ( // [R16]
    (i_hw_mode && strap == STRAP_MST_DS) [*3] |-> (o_bit_clock_oe_n == 2'b00))
    else $error("master strap not driving clocks");
  sw_speed_a: assert property ( // [R4]
    (!i_hw_mode && !s.ctrl[CTRL_AUTO]) |=> port_speed == $past(s.ctrl[CTRL_SPEED +: 2]))
    else $error("port speed not independent");
  line_route_a: assert property ( // [R3]
    (!i_hw_mode && s.ctrl[CTRL_LINE]) |=> o_line_bit_clock[0] == $past(port_bit[1]))
    else $error("output line not on port two");
  read_once_a: assert property (
    !i_rd_en |=> o_rd_data == 32'h0000_0000)
    else $error("read data held past one cycle");
endmodule : aspc_top

// >>> testbench.sv
// self-checking bench for the serial port clocking block
`timescale 1ns/100ps
module testbench
  import aspc_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic hw_mode = 1'b0;
  logic [1:0] strap = 2'h0; // {low pin, high pin}
  logic halve = 1'b0;
  logic [1:0][CNT_W-1:0] mdl_ratio = {R256, R256};
  logic [31:0] rd_data;
  logic mclk_one, mclk_two, async_mode;
  logic [1:0] o_bt, bt_oe_n, o_frm, frm_oe_n, m_frm, m_bt, frm, bt;
  logic [2:0] line_bt, line_frm;
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;
  localparam int TAB [2][4] = '{'{256, 384, 512, 768}, '{128, 192, 256, 384}};

  // pin level: the block while it drives, the far side otherwise
  assign frm = (o_frm & ~frm_oe_n) | (m_frm & frm_oe_n);
  assign bt = (o_bt & ~bt_oe_n) | (m_bt & bt_oe_n);

  aspc_top uut (.i_core_clk(core_clk), .i_rst_n(rst_n), .i_addr(addr), .i_wr_data(wdata),
    .i_wr_en(wr_en), .i_rd_en(rd_en), .o_rd_data(rd_data), .i_hw_mode(hw_mode),
    .i_strap_pin_low(strap[1]), .i_strap_pin_high(strap[0]),
    .i_master_clock_halve_pin(halve), .i_master_clock_one(mclk_one),
    .i_master_clock_two(mclk_two), .i_bit_clock(bt), .i_frame_clock(frm),
    .o_bit_clock(o_bt), .o_bit_clock_oe_n(bt_oe_n), .o_frame_clock(o_frm),
    .o_frame_clock_oe_n(frm_oe_n), .o_line_bit_clock(line_bt),
    .o_line_frame_clock(line_frm), .o_async_mode(async_mode));

  aspc_far_model far (.i_core_clk(core_clk), .i_sel(2'h0), .i_ratio(mdl_ratio),
    .o_mclk_one(mclk_one), .o_mclk_two(mclk_two), .o_frame(m_frm), .o_bit(m_bt));

  initial
  begin
    forever #12.5 core_clk = ~core_clk;
  end

  // hang guard, well above the longest expected run
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      err_count++;
      summarize();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
  endtask : wr

  // read data only stands in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    #1;
    d = rd_data;
  endtask : rd

  // master pulses and bit clock rises between two frame rises
  task automatic period(input int p, input bit src, output int n, output int b);
    int g;
    logic pf, pb;
    n = 0;
    b = 0;
    g = 0;
    pf = 1'b1;
    while (g < 4000)
    begin
      @(posedge core_clk);
      #1;
      g++;
      if (frm[p] && !pf)
        break;
      pf = frm[p];
    end
    pf = 1'b1;
    pb = bt[p];
    while (g < 8000)
    begin
      n += src ? mclk_two : mclk_one;
      @(posedge core_clk);
      #1;
      g++;
      b += (bt[p] && !pb) ? 1 : 0;
      pb = bt[p];
      if (frm[p] && !pf)
        break;
      pf = frm[p];
    end
  endtask : period

  task automatic t_reset();
    logic [31:0] d;
    chk("pin enables", {bt_oe_n, frm_oe_n}, 32'hF);
    chk("async", async_mode, 32'h0);
    wr(4'h3, 32'h3FF);
    rd(4'h3, d);
    chk("unmapped", d, 32'h0);
    rd(REG_CTRL, d);
    chk("ctrl", d, 32'h0);
    rd(REG_RATIO, d);
    chk("ratio", d, 32'h0);
    $display("done: reset");
  endtask : t_reset

  task automatic t_ratios();
    int n, b;
    for (int s = 0; s < 2; s++)
      for (int f = 0; f < 4; f++)
      begin
        wr(REG_RATIO, 32'(f));
        wr(REG_CTRL, 32'(4 + s));
        period(0, 1'b0, n, b);
        period(0, 1'b0, n, b);
        chk("frame ticks", 32'(n), 32'(TAB[s][f]));
        chk("bit clocks", 32'(b), 32'h40);
        chk("driving", frm_oe_n[0], 32'h0);
      end
    $display("done: ratios");
  endtask : t_ratios

  task automatic t_async();
    int n, b;
    logic [31:0] d;
    wr(REG_RATIO, 32'h0);
    wr(REG_CTRL, 32'h2E);
    repeat (4) @(posedge core_clk);
    chk("async on", async_mode, 32'h1);
    rd(REG_STATUS, d);
    chk("speeds", d[2:1], 32'h2);
    period(1, 1'b1, n, b);
    period(1, 1'b1, n, b);
    chk("port two on clock two", 32'(n), 32'h80);
    wr(REG_CTRL, 32'h0E);
    repeat (4) @(posedge core_clk);
    chk("async off", async_mode, 32'h0);
    period(1, 1'b0, n, b);
    period(1, 1'b0, n, b);
    chk("port two double", 32'(n), 32'h80);
    period(0, 1'b0, n, b);
    chk("port one single", 32'(n), 32'h100);
    $display("done: async");
  endtask : t_async

  task automatic t_slave();
    logic [31:0] d;
    mdl_ratio[0] <= R128;
    wr(REG_CTRL, 32'h40);
    repeat (1200) @(posedge core_clk);
    rd(REG_STATUS, d);
    chk("auto double", d[1], 32'h1);
    chk("locked", d[3], 32'h1);
    chk("count", d[15:6], 32'h80);
    chk("released", {bt_oe_n[0], frm_oe_n[0]}, 32'h3);
    mdl_ratio[0] <= R256;
    repeat (1800) @(posedge core_clk);
    rd(REG_STATUS, d);
    chk("auto single", d[1], 32'h0);
    wr(REG_CTRL, 32'h0);
    mdl_ratio[0] <= R384;
    repeat (2400) @(posedge core_clk);
    rd(REG_STATUS, d);
    chk("fixed mismatch", d[3], 32'h0);
    wr(REG_RATIO, 32'h1);
    repeat (2400) @(posedge core_clk);
    rd(REG_STATUS, d);
    chk("fixed match", d[3], 32'h1);
    $display("done: slave");
  endtask : t_slave

  task automatic t_lines();
    int bad;
    logic [1:0] pf, pb;
    bad = 0;
    wr(REG_CTRL, 32'h28E);
    repeat (8) @(posedge core_clk);
    #1;
    pf = o_frm;
    pb = o_bt;
    repeat (1200)
    begin
      @(posedge core_clk);
      #1;
      bad += (line_frm !== {pf[1], pf[0], pf[1]} || line_bt !== {pb[1], pb[0], pb[1]});
      pf = o_frm;
      pb = o_bt;
    end
    chk("line clocks", 32'(bad), 32'h0);
    $display("done: lines");
  endtask : t_lines

  task automatic t_hw();
    int n, b;
    logic [31:0] d;
    wr(REG_CTRL, 32'h10);
    hw_mode <= 1'b1;
    for (int c = 0; c < 2; c++)
      for (int h = 0; h < 2; h++)
      begin
        // pins move on a rising edge, like every other input
        @(posedge core_clk);
        strap <= 2'(c);
        halve <= 1'(h);
        period(0, 1'b0, n, b);
        period(0, 1'b0, n, b);
        chk("strap master", 32'(n), 32'(TAB[c][2 * h]));
        chk("no async", async_mode, 32'h0);
      end
    @(posedge core_clk);
    halve <= 1'b0;
    mdl_ratio[0] <= R128;
    for (int c = 2; c < 4; c++)
    begin
      strap <= 2'(c);
      repeat (1200) @(posedge core_clk);
      chk("strap released", {bt_oe_n, frm_oe_n}, 32'hF);
    end
    rd(REG_STATUS, d);
    chk("hw flag", d[5], 32'h1);
    chk("hw auto double", d[1], 32'h1);
    $display("done: hardware");
  endtask : t_hw

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize

  initial
  begin
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset();
    t_ratios();
    t_async();
    t_slave();
    t_lines();
    t_hw();
    summarize();
  end
endmodule : testbench
